/* design/gtd_consts.vh */
// Named constants for the trigger dispatcher: categories, function codes,
// action word layout, field dominance codes and reset values.
// Assumes inclusion by bare name from the design files.
`ifndef GTD_CONSTS_VH
`define GTD_CONSTS_VH

// Function categories
`define GTD_CAT_MISC 3'h0
`define GTD_CAT_KF 3'h1
`define GTD_CAT_AUTO 3'h2
`define GTD_CAT_CUT 3'h3
`define GTD_CAT_MEM 3'h4
`define GTD_CAT_FS 3'h5
`define GTD_CAT_LAST 3'h5

// Miscellaneous category functions
`define GTD_FN_AUX_TALLY 3'h0
`define GTD_FN_DISABLE 3'h1

// Number of functions in each pulse category
`define GTD_KF_CNT 3'h4
`define GTD_AUTO_CNT 3'h4
`define GTD_CUT_CNT 3'h3
`define GTD_MEM_CNT 3'h6
`define GTD_FS_CNT 3'h3

// Effects memory: codes 0..3 are recalls that use the register number
`define GTD_MEM_LAST_RECALL 3'h3

// Bit positions of each category inside the action word
`define GTD_KF_BASE 5'h00
`define GTD_AUTO_BASE 5'h04
`define GTD_CUT_BASE 5'h08
`define GTD_MEM_BASE 5'h0b
`define GTD_FS_BASE 5'h11
`define GTD_ACT_W 20

// Field dominance settings and field identity
`define GTD_DOM_NONE 2'h0
`define GTD_DOM_F1 2'h1
`define GTD_DOM_F2 2'h2
`define GTD_FIELD_ONE 1'b0
`define GTD_FIELD_TWO 1'b1

// Reset values of the selection and the assignment table
`define GTD_CAT_RESET 3'h0
`define GTD_FN_RESET 3'h1

`endif

/* design/gtd_sync_edge.v */
// Two-flop synchroniser with rising edge detector for a group of pins.
// Assumes asynchronous inputs and the single system clock.
`timescale 1ns/1ps
`default_nettype none

module gtd_sync_edge #(
   parameter W = 8
) (
   input wire CLK,            // System clock
   input wire RST_N,          // Synchronous reset, active low
   input wire [W-1:0] PIN,    // Asynchronous inputs
   output wire [W-1:0] LEVEL, // Synchronised level
   output wire [W-1:0] RISE   // One-cycle pulse on a rising edge
);

   reg [W-1:0] meta; // First stage, read only by the second
   reg [W-1:0] sync; // Second stage, safe to use
   reg [W-1:0] last; // Previous synchronised value

   ////////////////////////////////////////////////////////////////////////
   // Synchroniser chain and history flop
   always @(posedge CLK)
   begin
      if (!RST_N)
      begin
         meta <= {W{1'b0}};
         sync <= {W{1'b0}};
         last <= {W{1'b0}};
      end
      else
      begin
         meta <= PIN;
         sync <= meta;
         last <= sync;
      end
   end

   assign LEVEL = sync;
   // Each low-to-high change yields exactly one pulse
   assign RISE = sync & ~last;

endmodule
`default_nettype wire

/* design/gtd_dispatcher.v */
// Trigger dispatcher: eight contact inputs mapped to switcher functions,
// with field-aligned dispatch and a level-following aux tally path.
// Assumes FIELD_START and FIELD_ID come from video timing on CLK, and
// that configuration strobes are one-cycle pulses on CLK.
`timescale 1ns/1ps
`default_nettype none
`include "gtd_consts.vh"

module gtd_dispatcher #(
   parameter N_IN = 8,  // Number of trigger inputs
   parameter AUX_W = 4, // Aux bus number width
   parameter REG_W = 8  // Memory register number width
) (
   input wire CLK,                          // System video clock
   input wire RST_N,                        // Synchronous reset, low
   input wire [N_IN-1:0] GPI_IN,            // Contact inputs from pins
   input wire [2:0] CAT_SELECT,             // Category to select
   input wire CAT_LOAD,                     // Pulse: load CAT_SELECT
   input wire [2:0] SEL_INPUT,              // Input being assigned
   input wire [2:0] SEL_FUNCTION,           // Function within category
   input wire [AUX_W-1:0] SEL_AUX_BUS,      // Aux bus for tally
   input wire [REG_W-1:0] SEL_REGISTER,     // Register for recalls
   input wire COMMIT,                       // Pulse: commit_assignment
   input wire [1:0] DOMINANCE,              // Field dominance setting
   input wire FIELD_START,                  // Pulse: a field begins
   input wire FIELD_ID,                     // Field now starting
   input wire [2:0] VIEW_INPUT,             // Table row to display
   output reg [2:0] CUR_CATEGORY,           // Selected category
   output reg [2:0] VIEW_CATEGORY,          // Displayed row category
   output reg [2:0] VIEW_FUNCTION,          // Displayed row function
   output reg [AUX_W-1:0] VIEW_AUX_BUS,     // Displayed row aux bus
   output reg [REG_W-1:0] VIEW_REGISTER,    // Displayed row register
   output wire [3:0] KF_ACT,                // Keyframe action pulses
   output wire [3:0] AUTO_ACT,              // Auto transition pulses
   output wire [2:0] CUT_ACT,               // Cut pulses
   output wire [5:0] MEM_ACT,               // Effects memory pulses
   output reg [REG_W-1:0] MEM_REGISTER,     // Register for a recall
   output wire [2:0] FS_ACT,                // Frame store grab pulses
   output reg [(1<<AUX_W)-1:0] AUX_TALLY    // Tally level per aux bus
);

   localparam ACT_W = `GTD_ACT_W;

   wire [N_IN-1:0] lvl;               // Synchronised input levels
   wire [N_IN-1:0] rise;              // Edge pulses
   reg [3*N_IN-1:0] tab_cat;          // Committed category per input
   reg [3*N_IN-1:0] tab_fn;           // Committed function per input
   reg [AUX_W*N_IN-1:0] tab_aux;      // Committed aux bus per input
   reg [REG_W*N_IN-1:0] tab_reg;      // Committed register per input
   reg [N_IN-1:0] pend;               // Trigger waiting for its field
   wire [ACT_W*N_IN-1:0] req;         // Action word issued per input
   reg [ACT_W-1:0] act;               // Registered action pulses
   reg [ACT_W-1:0] next_act;          // Merged action word
   reg [REG_W-1:0] next_mem_reg;      // Register of the winning recall
   reg [(1<<AUX_W)-1:0] next_tally;   // Tally levels to apply
   reg field_ok;                      // This field start may dispatch
   integer i;                         // Loop index of the action merge
   integer j;                         // Loop index of the tally merge

   ////////////////////////////////////////////////////////////////////////
   // Action word for a category and function; out-of-range gives zero
   function [ACT_W-1:0] gtd_act_word;
      input [2:0] cat;
      input [2:0] fn;
      reg [4:0] base;
      reg [2:0] cnt;
      begin
         base = 5'h00;
         cnt = 3'h0;
         case (cat)
            `GTD_CAT_KF: // Keyframe run control
            begin
               base = `GTD_KF_BASE;
               cnt = `GTD_KF_CNT;
            end
            `GTD_CAT_AUTO: // Auto transitions
            begin
               base = `GTD_AUTO_BASE;
               cnt = `GTD_AUTO_CNT;
            end
            `GTD_CAT_CUT: // Immediate cuts
            begin
               base = `GTD_CUT_BASE;
               cnt = `GTD_CUT_CNT;
            end
            `GTD_CAT_MEM: // Effects memory actions
            begin
               base = `GTD_MEM_BASE;
               cnt = `GTD_MEM_CNT;
            end
            `GTD_CAT_FS: // Frame store grabs
            begin
               base = `GTD_FS_BASE;
               cnt = `GTD_FS_CNT;
            end
            default: // Misc issues no pulse action
            begin
               base = 5'h00;
               cnt = 3'h0;
            end
         endcase
         if (fn < cnt)
            gtd_act_word = {{(ACT_W-1){1'b0}}, 1'b1} << (base + {2'b00, fn});
         else
            gtd_act_word = {ACT_W{1'b0}};
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and edge detectors
   gtd_sync_edge #(
      .W(N_IN)
   ) u_sync (
      .CLK(CLK),
      .RST_N(RST_N),
      .PIN(GPI_IN),
      .LEVEL(lvl),
      .RISE(rise)
   );

   ////////////////////////////////////////////////////////////////////////
   // Category selection: always exactly one, bad codes are ignored
   always @(posedge CLK)
   begin
      if (!RST_N)
         CUR_CATEGORY <= `GTD_CAT_RESET;
      else if (CAT_LOAD && (CAT_SELECT <= `GTD_CAT_LAST))
         CUR_CATEGORY <= CAT_SELECT;
   end

   ////////////////////////////////////////////////////////////////////////
   // Field qualification against the dominance setting
   always @*
   begin
      case (DOMINANCE)
         `GTD_DOM_NONE: // Any field start will do
            field_ok = FIELD_START;
         `GTD_DOM_F1: // Wait for field one
            field_ok = FIELD_START && (FIELD_ID == `GTD_FIELD_ONE);
         `GTD_DOM_F2: // Wait for field two
            field_ok = FIELD_START && (FIELD_ID == `GTD_FIELD_TWO);
         default: // Unused code behaves as no dominance
            field_ok = FIELD_START;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Per-input assignment table, pending trigger and request word
   genvar g;
   generate
      for (g = 0; g < N_IN; g = g + 1)
      begin : g_in
         // Row number kept full width, compared on its low bits
         localparam [31:0] IDX = g;
         wire hit = COMMIT && (SEL_INPUT == IDX[2:0]); // Commit to this row
         wire [2:0] cat = tab_cat[3*g +: 3];
         wire [2:0] fn = tab_fn[3*g +: 3];
         // Only pulse categories accept edges; misc never queues
         wire pulse_cat = (cat != `GTD_CAT_MISC);
         wire take = rise[g] && pulse_cat;

         // Table row changes only on an explicit commit
         always @(posedge CLK)
         begin
            if (!RST_N)
            begin
               tab_cat[3*g +: 3] <= `GTD_CAT_MISC;
               tab_fn[3*g +: 3] <= `GTD_FN_RESET;
               tab_aux[AUX_W*g +: AUX_W] <= {AUX_W{1'b0}};
               tab_reg[REG_W*g +: REG_W] <= {REG_W{1'b0}};
            end
            else if (hit)
            begin
               tab_cat[3*g +: 3] <= CUR_CATEGORY;
               tab_fn[3*g +: 3] <= SEL_FUNCTION;
               tab_aux[AUX_W*g +: AUX_W] <= SEL_AUX_BUS;
               tab_reg[REG_W*g +: REG_W] <= SEL_REGISTER;
            end
         end

         // Pending flag: a new edge wins over dispatch or commit clear
         always @(posedge CLK)
         begin
            if (!RST_N)
               pend[g] <= 1'b0;
            else if (take)
               pend[g] <= 1'b1;
            else if (field_ok || hit)
               pend[g] <= 1'b0;
         end

         // One action word when the pending trigger meets its field
         assign req[ACT_W*g +: ACT_W] = (pend[g] && field_ok) ?
            gtd_act_word(cat, fn) : {ACT_W{1'b0}};
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Merge requests; lowest-numbered input supplies the recall register
   always @*
   begin
      next_act = {ACT_W{1'b0}};
      next_mem_reg = MEM_REGISTER;
      for (i = N_IN - 1; i >= 0; i = i - 1)
      begin
         next_act = next_act | req[ACT_W*i +: ACT_W];
         if (pend[i] && field_ok &&
             (tab_cat[3*i +: 3] == `GTD_CAT_MEM) &&
             (tab_fn[3*i +: 3] <= `GTD_MEM_LAST_RECALL))
            next_mem_reg = tab_reg[REG_W*i +: REG_W];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Aux tally: OR of the levels of all inputs assigned to each bus
   always @*
   begin
      next_tally = {(1<<AUX_W){1'b0}};
      for (j = 0; j < N_IN; j = j + 1)
      begin
         if ((tab_cat[3*j +: 3] == `GTD_CAT_MISC) &&
             (tab_fn[3*j +: 3] == `GTD_FN_AUX_TALLY) && lvl[j])
            next_tally[tab_aux[AUX_W*j +: AUX_W]] = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Output registers for actions, recall register and tally levels
   always @(posedge CLK)
   begin
      if (!RST_N)
      begin
         act <= {ACT_W{1'b0}};
         MEM_REGISTER <= {REG_W{1'b0}};
         AUX_TALLY <= {(1<<AUX_W){1'b0}};
      end
      else
      begin
         act <= next_act;
         MEM_REGISTER <= next_mem_reg;
         AUX_TALLY <= next_tally;
      end
   end

   assign KF_ACT = act[`GTD_KF_BASE +: 4];
   assign AUTO_ACT = act[`GTD_AUTO_BASE +: 4];
   assign CUT_ACT = act[`GTD_CUT_BASE +: 3];
   assign MEM_ACT = act[`GTD_MEM_BASE +: 6];
   assign FS_ACT = act[`GTD_FS_BASE +: 3];

   ////////////////////////////////////////////////////////////////////////
   // Displayed assignment table row, registered
   always @(posedge CLK)
   begin
      if (!RST_N)
      begin
         VIEW_CATEGORY <= `GTD_CAT_MISC;
         VIEW_FUNCTION <= `GTD_FN_RESET;
         VIEW_AUX_BUS <= {AUX_W{1'b0}};
         VIEW_REGISTER <= {REG_W{1'b0}};
      end
      else
      begin
         VIEW_CATEGORY <= tab_cat[3*VIEW_INPUT +: 3];
         VIEW_FUNCTION <= tab_fn[3*VIEW_INPUT +: 3];
         VIEW_AUX_BUS <= tab_aux[AUX_W*VIEW_INPUT +: AUX_W];
         VIEW_REGISTER <= tab_reg[REG_W*VIEW_INPUT +: REG_W];
      end
   end

endmodule
`default_nettype wire

/* tb/gtd_dispatcher_assertions.sv */
// Port checker for the trigger dispatcher.
// Assumes it is bound onto gtd_dispatcher with matching parameters.
`timescale 1ns/1ps
`default_nettype none
`include "gtd_consts.vh"

module gtd_checker #(
   parameter N_IN = 8, // Trigger inputs
   parameter AUX_W = 4, // Aux number width
   parameter REG_W = 8 // Register width
) (
   input wire CLK, // Clock
   input wire RST_N, // Reset, low
   input wire [N_IN-1:0] GPI_IN, // Contacts
   input wire [2:0] CAT_SELECT, // Category asked
   input wire CAT_LOAD, // Category load
   input wire [2:0] SEL_INPUT, // Row to commit
   input wire [2:0] SEL_FUNCTION, // Function to commit
   input wire COMMIT, // Commit strobe
   input wire [1:0] DOMINANCE, // Dominance
   input wire FIELD_START, // Field begins
   input wire FIELD_ID, // Field identity
   input wire [2:0] VIEW_INPUT, // Row shown
   input wire [2:0] CUR_CATEGORY, // Selected category
   input wire [2:0] VIEW_FUNCTION, // Shown function
   input wire [3:0] KF_ACT, // Keyframe pulses
   input wire [3:0] AUTO_ACT, // Auto pulses
   input wire [2:0] CUT_ACT, // Cut pulses
   input wire [5:0] MEM_ACT, // Memory pulses
   input wire [2:0] FS_ACT, // Grab pulses
   input wire [REG_W-1:0] MEM_REGISTER, // Recall register
   input wire [(1<<AUX_W)-1:0] AUX_TALLY // Tally levels
);
   ////////////////////////////////////////////////////////////////////////
   // Any action pulse in this cycle
   wire any_act = |{KF_ACT, AUTO_ACT, CUT_ACT, MEM_ACT, FS_ACT};
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_N);
   // Commit to the shown row, then two quiet cycles
   sequence s_commit_view;
      COMMIT && VIEW_INPUT == SEL_INPUT ##1
         (!COMMIT && $stable(VIEW_INPUT)) [*2];
   endsequence
   // Contacts open long enough to pass the synchroniser
   sequence s_pins_low;
      (GPI_IN == '0) [*4];
   endsequence
   AST_CAT_RANGE: assert property (CUR_CATEGORY <= `GTD_CAT_LAST)
      else $error("Category out of range");
   AST_CAT_LOAD: assert property (
      CAT_LOAD && CAT_SELECT <= `GTD_CAT_LAST
      |=> CUR_CATEGORY == $past(CAT_SELECT))
      else $error("Category not loaded");
   AST_CAT_HOLD: assert property (
      !CAT_LOAD |=> $stable(CUR_CATEGORY))
      else $error("Category changed without load");
   AST_FIELD_ALIGN: assert property (
      any_act |-> $past(FIELD_START))
      else $error("Action not aligned to a field start");
   AST_DOM_ONE: assert property (
      any_act && $past(DOMINANCE) == `GTD_DOM_F1
      |-> $past(FIELD_ID) == `GTD_FIELD_ONE)
      else $error("Action on field two");
   AST_DOM_TWO: assert property (
      any_act && $past(DOMINANCE) == `GTD_DOM_F2
      |-> $past(FIELD_ID) == `GTD_FIELD_TWO)
      else $error("Action on field one");
   AST_MEM_HOLD: assert property (
      MEM_ACT[3:0] == 4'h0 |-> $stable(MEM_REGISTER))
      else $error("Register moved without recall");
   AST_TALLY_LOW: assert property (
      s_pins_low |-> AUX_TALLY == '0)
      else $error("Tally high with open contacts");
   AST_VIEW_COMMIT: assert property (
      s_commit_view |=> VIEW_FUNCTION == $past(SEL_FUNCTION, 3))
      else $error("Table not shown");
endmodule

bind gtd_dispatcher gtd_checker #(.N_IN(N_IN), .AUX_W(AUX_W), .REG_W(REG_W))
   u_chk (.CLK(CLK), .RST_N(RST_N), .GPI_IN(GPI_IN), .CAT_SELECT(CAT_SELECT),
   .CAT_LOAD(CAT_LOAD), .SEL_INPUT(SEL_INPUT), .SEL_FUNCTION(SEL_FUNCTION),
   .COMMIT(COMMIT), .DOMINANCE(DOMINANCE), .FIELD_START(FIELD_START),
   .FIELD_ID(FIELD_ID), .VIEW_INPUT(VIEW_INPUT), .CUR_CATEGORY(CUR_CATEGORY),
   .VIEW_FUNCTION(VIEW_FUNCTION), .KF_ACT(KF_ACT), .AUTO_ACT(AUTO_ACT),
   .CUT_ACT(CUT_ACT), .MEM_ACT(MEM_ACT), .FS_ACT(FS_ACT),
   .MEM_REGISTER(MEM_REGISTER), .AUX_TALLY(AUX_TALLY));
`default_nettype wire

/* tb/gtd_contact_model.sv */
// Model of the external equipment closing the trigger contacts.
// Assumes one-cycle close requests; open contacts read low.
`timescale 1ns/1ps
`default_nettype none

module gtd_contact_model #(
   parameter CLOSE_LEN = 3 // Cycles a contact stays closed
) (
   input wire logic CLK, // Clock
   input wire logic [7:0] PRESS, // Close request per contact
   input wire logic [7:0] LEVEL, // Held tally level per contact
   output logic [7:0] GPI // Contact state
);
   ////////////////////////////////////////////////////////////////////////
   int cnt [8] = '{default: 0}; // Closed time left per contact
   // Count down each closure
   always @(posedge CLK)
      for (int i = 0; i < 8; i++)
         cnt[i] <= PRESS[i] ? CLOSE_LEN : (cnt[i] > 0 ? cnt[i] - 1 : 0);
   // Pulse closures and held tally levels share the pin
   always_comb
      for (int i = 0; i < 8; i++)
         GPI[i] = (cnt[i] != 0) | LEVEL[i];
endmodule
`default_nettype wire

/* tb/gtd_dispatcher_tb.sv */
// Self-checking bench for the trigger dispatcher.
// Assumes the contact model and the bound checker compile with it.
`timescale 1ns/1ps
`default_nettype none
`include "gtd_consts.vh"

module gtd_dispatcher_tb;
   logic CLK = 1'b0, RST_N = 1'b0, cat_load = 1'b0, commit = 1'b0;
   logic fstart = 1'b0, fid = 1'b0;
   logic [7:0] press = 8'h00, level = 8'h00, gpi, sel_reg = 8'h00, mreg;
   logic [2:0] cat_sel = 3'h0, sel_in = 3'h0, sel_fn = 3'h0, view_in = 3'h0;
   logic [3:0] sel_aux = 4'h9, v_aux, kf, au;
   logic [1:0] dom = 2'h0;
   logic [2:0] cur_cat, v_cat, v_fn, cu, fs;
   logic [5:0] me;
   logic [7:0] v_reg; // Shown row register
   logic [15:0] tally;
   logic [19:0] act, exp; // Seen and expected action pulses
   int n_fail = 0, check_count = 0, cyc = 0;
   // Rows: category, function, expected action bit (ff: none)
   logic [15:0] rows [21] = '{16'h1000, 16'h1101, 16'h1202, 16'h1303,
      16'h2004, 16'h2105, 16'h2206, 16'h2307, 16'h3008, 16'h3109, 16'h320a,
      16'h400b, 16'h410c, 16'h420d, 16'h430e, 16'h440f, 16'h4510, 16'h5011,
      16'h5112, 16'h5213, 16'h01ff};

   initial forever #5 CLK = ~CLK;

   gtd_contact_model u_model (.CLK(CLK), .PRESS(press), .LEVEL(level),
      .GPI(gpi));
   gtd_dispatcher dut (.CLK(CLK), .RST_N(RST_N), .GPI_IN(gpi),
      .CAT_SELECT(cat_sel), .CAT_LOAD(cat_load), .SEL_INPUT(sel_in),
      .SEL_FUNCTION(sel_fn), .SEL_AUX_BUS(sel_aux), .SEL_REGISTER(sel_reg),
      .COMMIT(commit), .DOMINANCE(dom), .FIELD_START(fstart), .FIELD_ID(fid),
      .VIEW_INPUT(view_in), .CUR_CATEGORY(cur_cat), .VIEW_CATEGORY(v_cat),
      .VIEW_FUNCTION(v_fn), .VIEW_AUX_BUS(v_aux), .VIEW_REGISTER(v_reg),
      .KF_ACT(kf), .AUTO_ACT(au), .CUT_ACT(cu), .MEM_ACT(me),
      .MEM_REGISTER(mreg), .FS_ACT(fs), .AUX_TALLY(tally));

   ////////////////////////////////////////////////////////////////////////
   // Print the counts and the verdict, then stop
   task report_and_stop;
      $display("Checks %0d, mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Compare one value
   task chk(input logic [31:0] got, input logic [31:0] want);
      check_count++;
      if (got !== want)
      begin
         n_fail++;
         $display("MISMATCH at %0t: got %h want %h", $time, got, want);
      end
   endtask
   // Load a category, then commit one row and show it
   task setup(input logic [2:0] in, cat, fn, input logic [7:0] rg);
      @(posedge CLK);
      cat_sel <= cat;
      cat_load <= 1'b1;
      @(posedge CLK);
      cat_load <= 1'b0;
      {sel_in, view_in, sel_fn, sel_reg} <= {in, in, fn, rg};
      commit <= 1'b1;
      @(posedge CLK);
      commit <= 1'b0;
      repeat (3) @(posedge CLK);
   endtask
   // Close one contact briefly and let it settle
   task hit(input logic [2:0] in);
      @(posedge CLK);
      press <= 8'h01 << in;
      @(posedge CLK);
      press <= 8'h00;
      repeat (8) @(posedge CLK);
   endtask
   // One field start, then capture the action pulses
   task field(input logic id);
      @(posedge CLK);
      fstart <= 1'b1;
      fid <= id;
      @(posedge CLK);
      fstart <= 1'b0;
      #1 act = {fs, me, cu, au, kf};
   endtask

   // Cut a hang short
   always @(posedge CLK)
   begin
      cyc++;
      if (cyc == 4000)
      begin
         n_fail++;
         report_and_stop;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (20) @(posedge CLK);
      RST_N <= 1'b1;
      @(posedge CLK);
      #1 chk(v_fn, `GTD_FN_RESET);
      chk(cur_cat, `GTD_CAT_RESET);
      // Every pulse-category function plus misc disable, one row each
      for (int r = 0; r < 21; r++)
      begin
         setup(r[2:0], rows[r][14:12], rows[r][10:8], 8'h30 + r[7:0]);
         chk(v_fn, rows[r][10:8]);
         chk(cur_cat, rows[r][14:12]);
         chk(v_cat, rows[r][14:12]);
         chk(v_aux, sel_aux);
         chk(v_reg, 8'h30 + r[7:0]);
         hit(r[2:0]);
         field(r[0]);
         exp = (rows[r][7:0] == 8'hff) ? 20'h0 : 20'h1 << rows[r][4:0];
         chk(act, exp);
         if (rows[r][14:12] == `GTD_CAT_MEM && rows[r][10:8] < 3'h4)
            chk(mreg, 8'h30 + r[7:0]);
      end
      // Dominance: the other field waits, the dominant one fires
      setup(3'h0, `GTD_CAT_KF, 3'h0, 8'h00);
      for (int d = 1; d < 3; d++)
      begin
         @(posedge CLK);
         dom <= d[1:0];
         hit(3'h0);
         field(d[0]);
         chk(act, 20'h0);
         field(~d[0]);
         chk(act, 20'h1);
      end
      // Tally row follows level; refused category; disabled row silent
      setup(3'h6, `GTD_CAT_MISC, `GTD_FN_AUX_TALLY, 8'h00);
      setup(3'h7, 3'h7, `GTD_FN_DISABLE, 8'h00);
      chk(cur_cat, `GTD_CAT_MISC);
      level <= 8'h40;
      dom <= `GTD_DOM_NONE;
      repeat (5) @(posedge CLK);
      chk(tally, 16'h0200);
      hit(3'h7);
      field(1'b0);
      chk(act, 20'h0);
      @(posedge CLK);
      level <= 8'h00;
      repeat (5) @(posedge CLK);
      chk(tally, 16'h0000);
      // Selection without commit changes nothing; pulses merge
      {sel_fn, cat_sel, cat_load} <= {3'h2, `GTD_CAT_CUT, 1'b1};
      dom <= 2'h3; // Spare code behaves as no dominance
      @(posedge CLK);
      cat_load <= 1'b0;
      hit(3'h0);
      hit(3'h0);
      field(1'b1);
      chk(act, 20'h1);
      field(1'b0);
      chk(act, 20'h0);
      // Second reset returns every row to disabled
      @(posedge CLK);
      RST_N <= 1'b0;
      repeat (20) @(posedge CLK);
      RST_N <= 1'b1;
      hit(3'h0);
      field(1'b0);
      chk(act, 20'h0);
      chk(cur_cat, `GTD_CAT_RESET);
      chk(v_fn, `GTD_FN_RESET);
      report_and_stop;
   end
endmodule
`default_nettype wire
